// ===== include/bsm_pkg.sv
// Package for the boot shadow memory map block.
// Assumes an 8-bit MCU core with a 16-bit code and data address space,
// and an APB master reaching the two control registers.
package bsm_pkg;

  // Register byte addresses on the APB side.
  localparam logic [11:0] BSM_SHADOW_CFG_ADDR = 12'h000;
  localparam logic [11:0] BSM_USB_CTRL_ADDR = 12'h004;

  // Field positions inside the shadow configuration register.
  localparam int BSM_SHADOW_BIT = 0;
  localparam int BSM_REV_LSB = 1;
  localparam int BSM_SIZE_LSB = 5;
  localparam int BSM_TYPE_BIT = 7;

  // Field position of the attach bit in the USB control register.
  localparam int BSM_ATTACH_BIT = 7;

  // Values after reset.
  localparam logic BSM_SHADOW_RESET = 1'h0;
  localparam logic BSM_ATTACH_RESET = 1'h0;

  // Fixed build straps. The revision value is arbitrary.
  localparam logic [3:0] BSM_REVISION = 4'h1;
  localparam logic [1:0] BSM_CODE_SIZE = 2'h2;
  localparam logic BSM_CODE_TYPE = 1'h1;

  // Code space windows.
  localparam logic [15:0] BSM_ROM_LO_BASE = 16'h0000;
  localparam logic [15:0] BSM_ROM_LO_LAST = 16'h17ff;
  localparam logic [15:0] BSM_ROM_HI_BASE = 16'h8000;
  localparam logic [15:0] BSM_ROM_HI_LAST = 16'h97ff;
  localparam logic [15:0] BSM_RAM_BASE = 16'h0000;
  localparam logic [15:0] BSM_RAM_LAST = 16'h3fff;

  // Data space windows.
  localparam logic [15:0] BSM_IO_BASE = 16'hf800;
  localparam logic [15:0] BSM_IO_LAST = 16'hffff;
  localparam logic [15:0] BSM_SCRATCH_LAST = 16'h00ff;

  // Address the core fetches from after reset.
  localparam logic [15:0] BSM_RESET_VECTOR = 16'h0000;

  // Target selected by a decode.
  typedef enum logic [2:0] {
    BSM_TGT_NONE = 3'b000,
    BSM_TGT_ROM = 3'b001,
    BSM_TGT_RAM = 3'b010,
    BSM_TGT_IO = 3'b011,
    BSM_TGT_SCRATCH = 3'b100
  } bsm_target_t;

endpackage : bsm_pkg

// ===== verilog/bsm_decode.sv
// Combinational address decoder for code, data and scratch spaces.
// Assumes the shadow select level comes from a register on the same clock.
`timescale 1ns/1ns
module bsm_decode
  import bsm_pkg::*;
(
  // Map control.
  input wire logic shadow_in,
  // Code fetch address.
  input wire logic [15:0] code_addr_in,
  // External data address and write strobe.
  input wire logic [15:0] data_addr_in,
  input wire logic data_wr_in,
  // Internal data address, eight bits.
  input wire logic [7:0] idata_addr_in,
  // Decoded targets.
  output bsm_target_t code_tgt_out,
  output bsm_target_t data_tgt_out,
  output bsm_target_t idata_tgt_out,
  output logic [15:0] code_off_out,
  output logic data_wr_ok_out
);

  // Code space decode; low space depends on the shadow select.
  always_comb begin
    code_tgt_out = BSM_TGT_NONE;
    code_off_out = code_addr_in;
    if (code_addr_in >= BSM_ROM_HI_BASE && code_addr_in <= BSM_ROM_HI_LAST) begin
      code_tgt_out = BSM_TGT_ROM;
      code_off_out = code_addr_in - BSM_ROM_HI_BASE;
    end else if (!shadow_in && code_addr_in <= BSM_ROM_LO_LAST) begin
      code_tgt_out = BSM_TGT_ROM;
    end else if (shadow_in && code_addr_in <= BSM_RAM_LAST) begin
      code_tgt_out = BSM_TGT_RAM;
    end
  end

  // Data space decode; the RAM leaves data space once shadowed.
  always_comb begin
    data_tgt_out = BSM_TGT_NONE;
    if (data_addr_in >= BSM_IO_BASE) begin
      data_tgt_out = BSM_TGT_IO;
    end else if (!shadow_in && data_addr_in <= BSM_RAM_LAST) begin
      data_tgt_out = BSM_TGT_RAM;
    end
  end

  // Writes reach RAM only in boot mode, since code space has no write path.
  assign data_wr_ok_out = data_wr_in && (data_tgt_out == BSM_TGT_RAM) && !shadow_in;

  // Internal scratch space is always its own target.
  assign idata_tgt_out = BSM_TGT_SCRATCH;

endmodule : bsm_decode

// ===== verilog/bsm_map.sv
// Boot shadow memory map: decode, shadow control and attach control.
// Assumes an APB master on mclk_in and an MCU core on the same clock.
//
// Notes on behaviour
// - Shadow clear: ROM low and at 8000.
// - Shadow clear: RAM read/write in data space.
// - F800 to FFFF always decodes to I/O.
// - Shadow set: ROM only at 8000.
// - Shadow set: RAM is code at 0000.
// - Shadow set: all RAM writes blocked.
// - Shadow bit set-only, cleared by reset.
// - Bits 4..1 read fixed revision.
// - Bits 6..5 read fixed code size.
// - Bit 7 reads fixed code memory type.
// - Reset clears shadow and attach.
// - First fetch at 0000 hits ROM.
// - Firmware loads RAM from EEPROM or USB.
// - Setting shadow moves 0000 to RAM.
// - Attach allowed only after map switch.
// - Scratch RAM at internal 00 to FF.
`timescale 1ns/1ns
module bsm_map
  import bsm_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // MCU code fetch side.
  input wire logic [15:0] code_addr_in,
  output logic code_rom_sel_out,
  output logic code_ram_sel_out,
  output logic [15:0] code_off_out,
  // MCU external data side.
  input wire logic [15:0] data_addr_in,
  input wire logic data_wr_in,
  output logic data_ram_sel_out,
  output logic data_ram_wr_out,
  output logic data_io_sel_out,
  // MCU internal data side.
  input wire logic [7:0] idata_addr_in,
  output logic scratch_sel_out,
  // Map and link status.
  output logic shadow_select_out,
  output logic usb_attach_out
);

  // All state of the block.
  typedef struct packed {
    logic shadow;
    logic attach;
    logic [31:0] rdata;
  } bsm_state_t;

  bsm_state_t st_r; // Registered state.
  bsm_state_t st_nxt; // Next state.

  bsm_target_t code_tgt; // Code decode result.
  bsm_target_t data_tgt; // Data decode result.
  bsm_target_t idata_tgt; // Internal data decode result.
  logic wr_ok; // Data write permitted into RAM.
  logic acc; // APB access phase.
  logic [7:0] cfg_rd; // Shadow configuration read image.
  logic [7:0] usb_rd; // USB control read image.

  // Address decoder shared by all three spaces.
  bsm_decode u_decode (
    .shadow_in(st_r.shadow),
    .code_addr_in(code_addr_in),
    .data_addr_in(data_addr_in),
    .data_wr_in(data_wr_in),
    .idata_addr_in(idata_addr_in),
    .code_tgt_out(code_tgt),
    .data_tgt_out(data_tgt),
    .idata_tgt_out(idata_tgt),
    .code_off_out(code_off_out),
    .data_wr_ok_out(wr_ok)
  );

  // The slave answers in the first access cycle, so no wait states.
  assign acc = psel_in && penable_in;
  assign pready_out = 1'b1;

  // Read images; the build fields are wired constants that reset never touches.
  always_comb begin
    cfg_rd = 8'h00;
    cfg_rd[BSM_SHADOW_BIT] = st_r.shadow;
    cfg_rd[BSM_REV_LSB +: 4] = BSM_REVISION;
    cfg_rd[BSM_SIZE_LSB +: 2] = BSM_CODE_SIZE;
    cfg_rd[BSM_TYPE_BIT] = BSM_CODE_TYPE;
    usb_rd = 8'h00;
    usb_rd[BSM_ATTACH_BIT] = st_r.attach;
  end

  // Unmapped addresses report an error rather than silently completing.
  assign pslverr_out = acc && (paddr_in != BSM_SHADOW_CFG_ADDR) &&
                       (paddr_in != BSM_USB_CTRL_ADDR);

  // Next-state logic for the control bits and the read data register.
  always_comb begin
    st_nxt = st_r;
    // Read data is captured during setup so it stands through the access.
    if (psel_in && !penable_in && !pwrite_in) begin
      if (paddr_in == BSM_SHADOW_CFG_ADDR) begin
        st_nxt.rdata = {24'h00_0000, cfg_rd};
      end else if (paddr_in == BSM_USB_CTRL_ADDR) begin
        st_nxt.rdata = {24'h00_0000, usb_rd};
      end else begin
        st_nxt.rdata = 32'h0000_0000;
      end
    end
    if (acc && pwrite_in) begin
      // A write of one sets the shadow bit; a write of zero is ignored.
      if (paddr_in == BSM_SHADOW_CFG_ADDR && pwdata_in[BSM_SHADOW_BIT]) begin
        st_nxt.shadow = 1'b1;
      end
      // Attach is held off until the map has switched, so the host never
      // enumerates a device still running from boot ROM.
      if (paddr_in == BSM_USB_CTRL_ADDR) begin
        st_nxt.attach = pwdata_in[BSM_ATTACH_BIT] && (st_r.shadow || st_r.attach);
      end
    end
    if (rst_in) begin
      st_nxt.shadow = BSM_SHADOW_RESET;
      st_nxt.attach = BSM_ATTACH_RESET;
      st_nxt.rdata = 32'h0000_0000;
    end
  end

  // State register.
  always_ff @(posedge mclk_in) begin
    st_r <= st_nxt;
  end

  assign prdata_out = st_r.rdata;

  // Code selects; after reset 0000 lands in ROM because shadow is clear.
  assign code_rom_sel_out = (code_tgt == BSM_TGT_ROM);
  assign code_ram_sel_out = (code_tgt == BSM_TGT_RAM);

  // Data selects; firmware's EEPROM or USB load goes through these.
  assign data_ram_sel_out = (data_tgt == BSM_TGT_RAM);
  assign data_ram_wr_out = wr_ok;
  assign data_io_sel_out = (data_tgt == BSM_TGT_IO);
  assign scratch_sel_out = (idata_tgt == BSM_TGT_SCRATCH) &&
                           ({8'h00, idata_addr_in} <= BSM_SCRATCH_LAST);

  assign shadow_select_out = st_r.shadow;
  assign usb_attach_out = st_r.attach;

endmodule : bsm_map

// ===== bench/bsm_map_props.sv
// Checker on the ports of the boot shadow map.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module bsm_map_props
  import bsm_pkg::*;
(
  input wire logic mclk_in, rst_in, psel_in, penable_in, pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [15:0] code_addr_in, data_addr_in, code_off_out,
  input wire logic data_wr_in, code_rom_sel_out, code_ram_sel_out, data_ram_sel_out,
  input wire logic data_ram_wr_out, data_io_sel_out, scratch_sel_out,
  input wire logic shadow_select_out, usb_attach_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  AST_ROM_LO: assert property (!shadow_select_out && code_addr_in <= 16'h17ff |-> code_rom_sel_out && !code_ram_sel_out) else $error("low rom");
  AST_ROM_HI: assert property (code_addr_in inside {[16'h8000:16'h97ff]} |-> code_rom_sel_out && code_off_out == code_addr_in - 16'h8000) else $error("high rom");
  AST_DATA_RAM: assert property (!shadow_select_out && data_addr_in <= 16'h3fff |-> data_ram_sel_out && data_ram_wr_out == data_wr_in) else $error("data ram");
  AST_IO: assert property (data_addr_in >= 16'hf800 |-> data_io_sel_out && !data_ram_sel_out) else $error("io window");
  AST_CODE_RAM: assert property (shadow_select_out && code_addr_in <= 16'h3fff |-> code_ram_sel_out && !code_rom_sel_out) else $error("code ram");
  AST_WR_BLOCK: assert property (shadow_select_out |-> !data_ram_wr_out && !data_ram_sel_out) else $error("ram write");
  AST_SET_ONLY: assert property (shadow_select_out |=> shadow_select_out) else $error("shadow cleared");
  AST_SET: assert property (psel_in && penable_in && pwrite_in && paddr_in == 12'h000 && pwdata_in[0] |=> shadow_select_out) else $error("shadow set");
  AST_RST: assert property (disable iff (1'b0) rst_in |=> !shadow_select_out && !usb_attach_out) else $error("reset");
  AST_ATTACH: assert property ($rose(usb_attach_out) |-> shadow_select_out) else $error("attach early");
  AST_SCRATCH: assert property (scratch_sel_out) else $error("scratch");
endmodule : bsm_map_props

bind bsm_map bsm_map_props i_bsm_map_props (.*);

// ===== bench/bsm_core_model.sv
// Core model: presents the fetch and data addresses the bench asks for.
// Assumes requests arrive on the clock of the map block.
`timescale 1ns/1ns
module bsm_core_model (
  input wire logic clk_in,
  input wire logic [15:0] c_req_in, d_req_in,
  input wire logic w_req_in,
  output logic [15:0] code_addr_out, data_addr_out,
  output logic data_wr_out,
  output logic [7:0] idata_addr_out = 8'h00
);
  // Addresses change just after an edge, as a fetch unit would.
  always @(posedge clk_in) begin
    code_addr_out <= c_req_in;
    data_addr_out <= d_req_in;
    data_wr_out <= w_req_in;
    idata_addr_out <= idata_addr_out + 8'h01;
  end
endmodule : bsm_core_model

// ===== bench/testbench.sv
// Self-checking bench for the boot shadow map.
// Assumes the core model drives the MCU side.
`timescale 1ns/1ns
module testbench
  import bsm_pkg::*;
;
  logic mclk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, w_req = 0;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, r;
  logic [15:0] code_addr_in, data_addr_in, code_off_out, c_req = 0, d_req = 0;
  logic [7:0] idata_addr_in;
  logic data_wr_in, pready_out, pslverr_out, code_rom_sel_out, code_ram_sel_out;
  logic data_ram_sel_out, data_ram_wr_out, data_io_sel_out, scratch_sel_out;
  logic shadow_select_out, usb_attach_out;
  int n_fail = 0, tests_run = 0, cyc = 0;
  logic [15:0] corner [12] = '{16'h0000, 16'h17ff, 16'h1800, 16'h3fff, 16'h4000, 16'h7fff,
    16'h8000, 16'h97ff, 16'h9800, 16'hf7ff, 16'hf800, 16'hffff};
  always #25 mclk_in = ~mclk_in;
  bsm_map i_bsm_map (.*);
  bsm_core_model i_bsm_core_model (.clk_in(mclk_in), .c_req_in(c_req), .d_req_in(d_req),
    .w_req_in(w_req), .code_addr_out(code_addr_in), .data_addr_out(data_addr_in),
    .data_wr_out(data_wr_in), .idata_addr_out(idata_addr_in));
  task print_verdict;
    $display("tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the idle cycle after it keeps drives apart.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1;
    do @(negedge mclk_in); while (pready_out !== 1'b1);
    r = prdata_out;
    chk({31'h0, pslverr_out}, {31'h0, !(a inside {12'h000, 12'h004})});
    @(posedge mclk_in);
    psel_in <= 0; penable_in <= 0;
    @(posedge mclk_in);
  endtask : apb
  function automatic logic [31:0] exp_map(logic s, logic [15:0] c, logic [15:0] d, logic w);
    logic hi;
    hi = c inside {[16'h8000:16'h97ff]};
    return {10'h0, hi ? c - 16'h8000 : c, hi || (!s && c <= 16'h17ff), s && c <= 16'h3fff,
      !s && d <= 16'h3fff, !s && d <= 16'h3fff && w, d >= 16'hf800, 1'b1};
  endfunction : exp_map
  // Corner addresses first, then random ones.
  task automatic map_run(input logic s);
    for (int i = 0; i < 40; i++) begin
      c_req <= i < 12 ? corner[i] : 16'($urandom);
      d_req <= i < 12 ? corner[11 - i] : 16'($urandom);
      w_req <= 1'($urandom);
      @(posedge mclk_in);
      @(posedge mclk_in);
      @(negedge mclk_in);
      chk({10'h0, code_off_out, code_rom_sel_out, code_ram_sel_out, data_ram_sel_out,
        data_ram_wr_out, data_io_sel_out, scratch_sel_out}, exp_map(s, c_req, d_req, w_req));
    end
    @(posedge mclk_in);
    $display("map test done, shadow %0d", s);
  endtask : map_run
  task automatic rd_cfg(input logic s);
    apb(0, BSM_SHADOW_CFG_ADDR, 0);
    chk(r, {24'h0, BSM_CODE_TYPE, BSM_CODE_SIZE, BSM_REVISION, s});
  endtask : rd_cfg
  // Hang guard.
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    void'($urandom(32'h5e33c8cf));
    repeat (2) @(posedge mclk_in);
    rst_in <= 0;
    @(posedge mclk_in);
    rd_cfg(0);
    apb(1, BSM_USB_CTRL_ADDR, 32'h0000_0080);
    chk(usb_attach_out, 0);
    map_run(0);
    apb(1, BSM_SHADOW_CFG_ADDR, 0);
    chk(shadow_select_out, 0);
    apb(1, BSM_SHADOW_CFG_ADDR, 32'h0000_00ff);
    apb(1, BSM_SHADOW_CFG_ADDR, 0);
    rd_cfg(1);
    map_run(1);
    apb(1, BSM_USB_CTRL_ADDR, 32'h0000_0080);
    apb(0, BSM_USB_CTRL_ADDR, 0);
    chk(r, 32'h0000_0080);
    apb(0, 12'h008, 0);
    rst_in <= 1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 0;
    @(posedge mclk_in);
    chk({shadow_select_out, usb_attach_out}, 0);
    rd_cfg(0);
    $display("register test done");
    print_verdict;
  end
endmodule : testbench
